// *** testbench/gpo_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpo_pin_model (
  // pad drive from the port
  input wire logic [7:0] drv,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  // level that outside circuitry puts on undriven pads
  input wire logic [7:0] ext,
  // level seen back at the port
  output logic [7:0] pin
);
  // a driven pad follows drv; an undriven pad with its pull-up on floats high; otherwise the outside source wins
  assign pin = (oe & drv) | (~oe & pull) | (~oe & ~pull & ext);
endmodule // gpo_pin_model
`default_nettype wire

// *** testbench/port_pin_override_and_io_registers_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_pin_override_and_io_registers_test;
  import gpo_pkg::*;
  logic clk_sys;
  logic rst_n;
  gpo_bus_s bus;
  gpo_periph_s periph;
  logic [7:0] rdata, pa_in, pa_out, pa_oe, pa_pu, pb_in, pb_out, pb_oe, pb_pu, ext_a, ext_b;
  logic pcs8, sin;
  int num_errors = 0;
  int cmp_count = 0;
  gpo_port u_gpo_port (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .periph(periph), .pin_change_source_eight(pcs8), .serial_in_line(sin),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pu));
  gpo_pin_model u_gpo_pin_model_a (.drv(pa_out), .oe(pa_oe), .pull(pa_pu), .ext(ext_a), .pin(pa_in));
  gpo_pin_model u_gpo_pin_model_b (.drv(pb_out), .oe(pb_oe), .pull(pb_pu), .ext(ext_b), .pin(pb_in));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // pins need the register edge, the pad edge and two sync edges
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rc(GPO_A_VALUE, 8'h00);
    rc(GPO_A_DIR, 8'h00);
    rc(GPO_B_VALUE, 8'h00);
    rc(GPO_B_DIR, 8'h00);
    wr(GPO_A_VALUE, 8'ha5);
    rc(GPO_A_VALUE, 8'ha5);
    wr(GPO_A_DIR, 8'h3c);
    rc(GPO_A_DIR, 8'h3c);
    wr(GPO_B_VALUE, 8'h5a);
    rc(GPO_B_VALUE, 8'h5a);
    wr(GPO_B_DIR, 8'hc3);
    rc(GPO_B_DIR, 8'hc3);
    wr(3'h7, 8'hff);
    rc(3'h7, 8'h00);
  endtask
  task automatic t_port_a;
    wr(GPO_A_DIR, 8'h00);
    wr(GPO_A_VALUE, 8'h00);
    ext_a <= 8'h96;
    settle;
    rc(GPO_A_SAMPLE, 8'h96);
    wr(GPO_A_VALUE, 8'h0f);
    settle;
    chk(pa_pu, 8'h0f);
    rc(GPO_A_SAMPLE, 8'h9f);
    wr(GPO_A_SAMPLE, 8'h05);
    rc(GPO_A_VALUE, 8'h0a);
    wr(GPO_A_DIR, 8'hff);
    settle;
    chk(pa_out, 8'h0a);
    chk(pa_oe, 8'hff);
    chk(pa_pu, 8'h00);
    rc(GPO_A_SAMPLE, 8'h0a);
  endtask
  task automatic t_port_b;
    wr(GPO_B_DIR, 8'h0f);
    wr(GPO_B_VALUE, 8'h33);
    settle;
    chk(pb_oe, 8'h0f);
    chk(pb_out, 8'h03);
    chk(pb_pu, 8'h30);
    rc(GPO_B_SAMPLE, 8'h33);
    wr(GPO_B_SAMPLE, 8'hf0);
    rc(GPO_B_VALUE, 8'hc3);
  endtask
  task automatic t_timer;
    wr(GPO_B_DIR, 8'hff);
    wr(GPO_B_VALUE, 8'h00);
    wr(GPO_STEER, 8'h07);
    periph.timer_out_a_active <= 1'b1;
    periph.timer_out_b_active <= 1'b1;
    periph.timer_compare_out_a <= 1'b1;
    periph.timer_compare_out_b <= 1'b1;
    settle;
    chk(pb_out, 8'h07);
    @(posedge clk_sys);
    periph.timer_out_b_active <= 1'b0;
    settle;
    chk(pb_out, 8'h05);
    wr(GPO_B_DIR, 8'hfe);
    settle;
    chk(pb_out & 8'h01, 8'h00);
    wr(GPO_B_DIR, 8'hff);
    periph.serial_two_wire_active <= 1'b1;
    periph.serial_alt_position <= 1'b1;
    settle;
    chk(pb_out & 8'h05, 8'h00);
    chk(pb_oe & 8'h01, 8'h00);
    @(posedge clk_sys);
    periph.serial_shift_output <= 1'b1;
    periph.serial_clock_stretch <= 1'b1;
    settle;
    chk(pb_oe & 8'h05, 8'h05);
    @(posedge clk_sys);
    periph.serial_two_wire_active <= 1'b0;
    periph.serial_three_wire_active <= 1'b1;
    settle;
    chk(pb_out & 8'h07, 8'h07);
    @(posedge clk_sys);
    periph.serial_shift_output <= 1'b0;
    settle;
    chk(pb_out & 8'h07, 8'h05);
  endtask
  task automatic t_input;
    wr(GPO_B_DIR, 8'h00);
    wr(GPO_B_VALUE, 8'h00);
    periph.pin_change_group_enable <= 1'b1;
    periph.pin_change_mask <= 8'h01;
    ext_b <= 8'h01;
    settle;
    chk({7'h00, pcs8}, 8'h01);
    chk({7'h00, sin}, 8'h01);
    @(posedge clk_sys);
    ext_b <= 8'h00;
    settle;
    chk({7'h00, pcs8}, 8'h00);
    chk({7'h00, sin}, 8'h00);
    @(posedge clk_sys);
    ext_b <= 8'h01;
    periph.pin_change_group_enable <= 1'b0;
    periph.serial_start_irq_enable <= 1'b1;
    settle;
    chk({7'h00, pcs8}, 8'h01);
    wr(GPO_B_DIR, 8'h01);
    periph.serial_start_irq_enable <= 1'b0;
    settle;
    chk({7'h00, sin}, 8'h00);
    chk({7'h00, pcs8}, 8'h00);
  endtask
  task automatic t_reset_pin;
    // plain port, with the outside world pulling the reset pad high
    periph <= '{reset_pin_mode: 1'b1, default: '0};
    ext_b <= 8'h80;
    wr(GPO_B_DIR, 8'hff);
    wr(GPO_B_VALUE, 8'hff);
    rc(GPO_B_DIR, 8'h7f);
    rc(GPO_B_VALUE, 8'h7f);
    rc(GPO_B_SAMPLE, 8'h7f);
    chk(pb_oe, 8'h7f);
    chk(pb_pu, 8'h00);
  endtask
  initial begin
    bus = '0;
    periph = '0;
    ext_a = 8'h00;
    ext_b = 8'h00;
    rst_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1 chk(pb_oe | pa_oe, 8'h00);
    t_regs;
    t_port_a;
    t_port_b;
    t_timer;
    t_input;
    t_reset_pin;
    tally_and_finish;
  end
  // about 155 cycles of traffic; the limit of 10000 cycles leaves ample margin
  initial begin
    #200000;
    num_errors++;
    tally_and_finish;
  end
endmodule // port_pin_override_and_io_registers_test
`default_nettype wire

// *** verilog/gpo_pkg.sv ***
package gpo_pkg;
  localparam int unsigned GPO_AW = 3;
  localparam int unsigned GPO_DW = 8;
  localparam logic [GPO_AW-1:0] GPO_A_SAMPLE = 3'h0;
  localparam logic [GPO_AW-1:0] GPO_A_DIR = 3'h1;
  localparam logic [GPO_AW-1:0] GPO_A_VALUE = 3'h2;
  localparam logic [GPO_AW-1:0] GPO_B_SAMPLE = 3'h3;
  localparam logic [GPO_AW-1:0] GPO_B_DIR = 3'h4;
  localparam logic [GPO_AW-1:0] GPO_B_VALUE = 3'h5;
  localparam logic [GPO_AW-1:0] GPO_STEER = 3'h6;
  localparam logic [GPO_DW-1:0] GPO_RESET_VALUE = 8'h00;
  localparam int unsigned GPO_BIT_DATA = 0;
  localparam int unsigned GPO_BIT_DOUT = 1;
  localparam int unsigned GPO_BIT_CLK = 2;
  localparam int unsigned GPO_BIT_RST = 7;
  // register bus layout (3-bit address, 8-bit write data, write and read strobes)
  typedef struct packed {
    logic [GPO_AW-1:0] addr;
    logic [GPO_DW-1:0] wdata;
    logic wr;
    logic rd;
  } gpo_bus_s;
  typedef struct packed {
    logic timer_out_a_active;
    logic timer_out_b_active;
    logic timer_compare_out_a;
    logic timer_compare_out_b;
    logic serial_two_wire_active;
    logic serial_three_wire_active;
    logic serial_alt_position;
    logic serial_shift_output;
    logic serial_clock_stretch;
    logic serial_start_irq_enable;
    logic pin_change_group_enable;
    logic [GPO_DW-1:0] pin_change_mask;
    logic reset_pin_mode;
  } gpo_periph_s;
endpackage

// *** verilog/gpo_port.sv ***
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpo_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire gpo_pkg::gpo_bus_s bus,
  output logic [gpo_pkg::GPO_DW-1:0] rdata,
  // peripheral override controls
  input wire gpo_pkg::gpo_periph_s periph,
  output logic pin_change_source_eight,
  output logic serial_in_line,
  // first port pins
  input wire logic [gpo_pkg::GPO_DW-1:0] pa_in,
  output logic [gpo_pkg::GPO_DW-1:0] pa_out,
  output logic [gpo_pkg::GPO_DW-1:0] pa_oe,
  output logic [gpo_pkg::GPO_DW-1:0] pa_pullup,
  // second port pins
  input wire logic [gpo_pkg::GPO_DW-1:0] pb_in,
  output logic [gpo_pkg::GPO_DW-1:0] pb_out,
  output logic [gpo_pkg::GPO_DW-1:0] pb_oe,
  output logic [gpo_pkg::GPO_DW-1:0] pb_pullup
);
  import gpo_pkg::*;

  // ----------------------------------------
  // registers and pin synchronisers
  // ----------------------------------------
  logic [GPO_DW-1:0] first_port_output_value;
  logic [GPO_DW-1:0] first_port_direction;
  logic [GPO_DW-1:0] second_port_output_value;
  logic [GPO_DW-1:0] second_port_direction;
  logic [GPO_DW-1:0] timer_output_steering_reg;
  logic [GPO_DW-1:0] pa_meta, pa_sync, pb_meta, pb_sync;

  // pins pass two flops before anything reads them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pa_meta <= GPO_RESET_VALUE;
      pa_sync <= GPO_RESET_VALUE;
      pb_meta <= GPO_RESET_VALUE;
      pb_sync <= GPO_RESET_VALUE;
    end else begin
      pa_meta <= pa_in;
      pa_sync <= pa_meta;
      pb_meta <= pb_in;
      pb_sync <= pb_meta;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  function automatic logic hit(input gpo_bus_s b, input logic [GPO_AW-1:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  wire logic rst_pin = periph.reset_pin_mode;
  wire logic [GPO_DW-1:0] rst_mask = GPO_DW'(rst_pin) << GPO_BIT_RST;
  wire logic [GPO_DW-1:0] next_a_value = hit(bus, GPO_A_VALUE) ? bus.wdata :
    hit(bus, GPO_A_SAMPLE) ? (first_port_output_value ^ bus.wdata)
    : first_port_output_value;
  wire logic [GPO_DW-1:0] next_b_value = hit(bus, GPO_B_VALUE) ? bus.wdata :
    hit(bus, GPO_B_SAMPLE) ? (second_port_output_value ^ bus.wdata)
    : second_port_output_value;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      first_port_output_value <= GPO_RESET_VALUE;
      first_port_direction <= GPO_RESET_VALUE;
      second_port_output_value <= GPO_RESET_VALUE;
      second_port_direction <= GPO_RESET_VALUE;
      timer_output_steering_reg <= GPO_RESET_VALUE;
    end else begin
      first_port_output_value <= next_a_value;
      second_port_output_value <= next_b_value & ~rst_mask;
      if (hit(bus, GPO_A_DIR)) begin
        first_port_direction <= bus.wdata;
      end
      if (hit(bus, GPO_B_DIR)) begin
        second_port_direction <= bus.wdata & ~rst_mask;
      end else begin
        second_port_direction <= second_port_direction & ~rst_mask;
      end
      if (hit(bus, GPO_STEER)) begin
        timer_output_steering_reg <= bus.wdata;
      end
    end
  end

  // ----------------------------------------
  // read path, data one cycle after strobe
  // ----------------------------------------
  logic [GPO_DW-1:0] next_rdata;
  always_comb begin
    case (bus.addr)
      GPO_A_SAMPLE: next_rdata = pa_sync;
      GPO_A_DIR: next_rdata = first_port_direction;
      GPO_A_VALUE: next_rdata = first_port_output_value;
      GPO_B_SAMPLE: next_rdata = pb_sync & ~rst_mask;
      GPO_B_DIR: next_rdata = second_port_direction;
      GPO_B_VALUE: next_rdata = second_port_output_value;
      GPO_STEER: next_rdata = timer_output_steering_reg;
      default: next_rdata = GPO_RESET_VALUE;
    endcase
  end

  // ----------------------------------------
  // second port override logic
  // ----------------------------------------
  wire logic tw_alt = periph.serial_two_wire_active & periph.serial_alt_position;
  wire logic thw_alt = periph.serial_three_wire_active & periph.serial_alt_position;
  wire logic direction_bit_zero = second_port_direction[GPO_BIT_DATA];
  wire logic port_b_direction_two = second_port_direction[GPO_BIT_CLK];
  wire logic port_b_value_zero = second_port_output_value[GPO_BIT_DATA];
  wire logic port_b_value_one = second_port_output_value[GPO_BIT_DOUT];
  logic [GPO_DW-1:0] tmr_en, tmr_val, pv_oe, pv_ov, dd_oe, dd_ov;
  // even pins carry channel A, odd pins channel B
  genvar gi;
  generate
    for (gi = 0; gi < GPO_DW; gi++) begin : g_tmr
      if (gi % 2 == 0) begin : g_a
        assign tmr_en[gi] = periph.timer_out_a_active & timer_output_steering_reg[gi];
        assign tmr_val[gi] = periph.timer_compare_out_a;
      end else begin : g_b
        assign tmr_en[gi] = periph.timer_out_b_active & timer_output_steering_reg[gi];
        assign tmr_val[gi] = periph.timer_compare_out_b;
      end
    end
  endgenerate

  wire logic sda_low = tw_alt & direction_bit_zero;
  wire logic scl_low = tw_alt & port_b_direction_two;
  // three-wire output drives pin 1 in place of timer B
  wire logic do_sel = (periph.serial_two_wire_active | periph.serial_three_wire_active)
    & periph.serial_alt_position;
  always_comb begin
    pv_oe = tmr_en;
    pv_ov = tmr_val;
    dd_oe = GPO_RESET_VALUE;
    dd_ov = GPO_RESET_VALUE;
    pv_oe[GPO_BIT_DATA] = sda_low | tmr_en[GPO_BIT_DATA];
    pv_ov[GPO_BIT_DATA] = sda_low ? 1'b0 : tmr_val[GPO_BIT_DATA];
    pv_oe[GPO_BIT_CLK] = scl_low | tmr_en[GPO_BIT_CLK];
    pv_ov[GPO_BIT_CLK] = scl_low ? 1'b0 : tmr_val[GPO_BIT_CLK];
    pv_oe[GPO_BIT_DOUT] = (do_sel & thw_alt) | tmr_en[GPO_BIT_DOUT];
    pv_ov[GPO_BIT_DOUT] = do_sel ? periph.serial_shift_output : tmr_val[GPO_BIT_DOUT];
    dd_oe[GPO_BIT_DATA] = tw_alt;
    dd_ov[GPO_BIT_DATA] = (periph.serial_shift_output | port_b_value_zero)
      & direction_bit_zero;
    dd_oe[GPO_BIT_CLK] = tw_alt;
    dd_ov[GPO_BIT_CLK] = (periph.serial_clock_stretch | second_port_output_value[GPO_BIT_CLK])
      & port_b_direction_two;
  end

  // value applies only when the effective direction is output; pull-up on inputs
  wire logic [GPO_DW-1:0] b_dir = (dd_oe & dd_ov) | (~dd_oe & second_port_direction);
  wire logic [GPO_DW-1:0] b_val = (pv_oe & pv_ov) | (~pv_oe & second_port_output_value);
  wire logic [GPO_DW-1:0] b_pu = ~b_dir & second_port_output_value & ~rst_mask;
  wire logic pc_en = (periph.serial_start_irq_enable & periph.serial_alt_position)
    | (periph.pin_change_group_enable & periph.pin_change_mask[GPO_BIT_DATA]);

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= GPO_RESET_VALUE;
      pa_out <= GPO_RESET_VALUE;
      pa_oe <= GPO_RESET_VALUE;
      pa_pullup <= GPO_RESET_VALUE;
      pb_out <= GPO_RESET_VALUE;
      pb_oe <= GPO_RESET_VALUE;
      pb_pullup <= GPO_RESET_VALUE;
      pin_change_source_eight <= 1'b0;
      serial_in_line <= 1'b0;
    end else begin
      rdata <= bus.rd ? next_rdata : GPO_RESET_VALUE;
      pa_out <= first_port_output_value & first_port_direction;
      pa_oe <= first_port_direction;
      pa_pullup <= first_port_output_value & ~first_port_direction;
      pb_out <= b_val & b_dir & ~rst_mask;
      pb_oe <= b_dir & ~rst_mask;
      pb_pullup <= b_pu;
      pin_change_source_eight <= pc_en & pb_sync[GPO_BIT_DATA];
      // serial input sees the pin while it is an input, and always in two-wire mode
      serial_in_line <= pb_sync[GPO_BIT_DATA] & (~direction_bit_zero | tw_alt);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // the data pin may only ever pull low in two-wire mode while its direction bit is set
  chk_sda_low_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tw_alt && direction_bit_zero)
      |=> !pb_out[GPO_BIT_DATA])
    else $error("data pin driven high in two-wire mode");
  chk_timer_needs_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!tw_alt && !direction_bit_zero) |=> !pb_oe[GPO_BIT_DATA])
    else $error("data pin driven while direction is input");
  chk_toggle_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit(bus, GPO_A_SAMPLE) |=>
      first_port_output_value == ($past(first_port_output_value) ^ $past(bus.wdata)))
    else $error("sample write did not toggle value");
  chk_reset_pin_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rst_pin && bus.rd) |=> rdata[GPO_BIT_RST] == 1'b0)
    else $error("reset pin bit read nonzero");
  chk_dout_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (thw_alt && second_port_direction[GPO_BIT_DOUT])
      |=> pb_out[GPO_BIT_DOUT] == $past(periph.serial_shift_output))
    else $error("serial output not on pin one");
  chk_plain_port_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> pa_oe == $past(first_port_direction))
    else $error("first port direction not applied");
  chk_timer_steer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!timer_output_steering_reg[3] && !periph.serial_alt_position)
      |=> pb_out[3] == $past(second_port_output_value[3] & second_port_direction[3]))
    else $error("unsteered pin took timer value");
  chk_pin_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pc_en |=> !pin_change_source_eight)
    else $error("pin change seen while disabled");

  // pin overrides on the second port
  chk_scl_low_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tw_alt && port_b_direction_two)
      |=> !pb_out[GPO_BIT_CLK])
    else $error("clock pin driven high in two-wire mode");
  chk_sda_dir_open: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tw_alt
      |=> pb_oe[GPO_BIT_DATA] == $past((periph.serial_shift_output | port_b_value_zero) & direction_bit_zero))
    else $error("data pin direction not open-drain style");
  chk_timer_a_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!tw_alt && periph.timer_out_a_active && timer_output_steering_reg[GPO_BIT_DATA] && direction_bit_zero)
      |=> pb_out[GPO_BIT_DATA] == $past(periph.timer_compare_out_a))
    else $error("steered timer a value missing on data pin");
  chk_dout_timer_b: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!periph.serial_alt_position && periph.timer_out_b_active
      && timer_output_steering_reg[GPO_BIT_DOUT] && second_port_direction[GPO_BIT_DOUT])
      |=> pb_out[GPO_BIT_DOUT] == $past(periph.timer_compare_out_b))
    else $error("steered timer b value missing on pin one");
  chk_dout_pullup: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (thw_alt && !second_port_direction[GPO_BIT_DOUT])
      |=> pb_pullup[GPO_BIT_DOUT] == $past(port_b_value_one))
    else $error("pin one pull-up lost in three-wire mode");
  chk_reset_pin_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_pin
      |=> !pb_oe[GPO_BIT_RST] && !pb_pullup[GPO_BIT_RST])
    else $error("reset pin driven or pulled");
  chk_reset_dir_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_pin
      |=> !second_port_direction[GPO_BIT_RST] && !second_port_output_value[GPO_BIT_RST])
    else $error("reset pin stored bits not cleared");

  // register writes
  chk_a_value_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit(bus, GPO_A_VALUE)
      |=> first_port_output_value == $past(bus.wdata))
    else $error("first port value write lost");
  chk_a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit(bus, GPO_A_DIR)
      |=> first_port_direction == $past(bus.wdata))
    else $error("first port direction write lost");
  chk_b_value_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit(bus, GPO_B_VALUE)
      |=> second_port_output_value == ($past(bus.wdata) & ~$past(rst_mask)))
    else $error("second port value write lost");
  chk_b_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit(bus, GPO_B_DIR)
      |=> second_port_direction == ($past(bus.wdata) & ~$past(rst_mask)))
    else $error("second port direction write lost");
  chk_b_toggle_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit(bus, GPO_B_SAMPLE)
      |=> second_port_output_value == (($past(second_port_output_value) ^ $past(bus.wdata)) & ~$past(rst_mask)))
    else $error("second port sample write did not toggle");

  // read and input paths, and first port drive
  chk_a_sample_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == GPO_A_SAMPLE)
      |=> rdata == $past(pa_sync))
    else $error("first port sample read wrong");
  chk_b_sample_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == GPO_B_SAMPLE)
      |=> rdata == ($past(pb_sync) & ~$past(rst_mask)))
    else $error("second port sample read wrong");
  chk_serial_in_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!tw_alt && direction_bit_zero)
      |=> !serial_in_line)
    else $error("serial input seen while pin is output");
  chk_sda_input_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tw_alt
      |=> serial_in_line == $past(pb_sync[GPO_BIT_DATA]))
    else $error("data line input lost in two-wire mode");
  chk_pin_change_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pc_en
      |=> pin_change_source_eight == $past(pb_sync[GPO_BIT_DATA]))
    else $error("pin change source does not follow pin");
  chk_port_a_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1
      |=> pa_out == $past(first_port_output_value & first_port_direction)
        && pa_pullup == $past(first_port_output_value & ~first_port_direction))
    else $error("first port pins do not follow registers");
endmodule // gpo_port
`default_nettype wire
